// ### hw/otp_pkg.sv
// Purpose: shared constants for the one-time-programmable memory access controller
// Assumes: 8-bit register port with 16-bit addresses, single 50 MHz clock
// Notes: timing of programming pulses is counted in register-loaded clock cycles
package otp_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [15:0] OTP_ADDR_CTRL = 16'h3200;
   localparam logic [15:0] OTP_ADDR_STATUS = 16'h3201;
   localparam logic [15:0] OTP_ADDR_PAGE = 16'h3202;
   localparam logic [15:0] OTP_ADDR_BUF_FIRST = 16'h3204;
   localparam logic [15:0] OTP_ADDR_BUF_LAST = 16'h3243;
   localparam logic [15:0] OTP_ADDR_MODE = 16'h3300;
   localparam logic [15:0] OTP_ADDR_CNT_HI = 16'h3302;
   localparam logic [15:0] OTP_ADDR_CNT_LO = 16'h3303;
   // ****************************************
   // field positions and values
   // ****************************************
   localparam int OTP_CTRL_EN = 0;
   localparam int OTP_CTRL_WR = 1;
   localparam int OTP_CTRL_ERRCLR = 2;
   localparam logic [1:0] OTP_CTRL_PROG = 2'h3;
   localparam logic [1:0] OTP_CTRL_READ = 2'h1;
   localparam int OTP_ST_RDRDY = 0;
   localparam int OTP_ST_WRRDY = 1;
   localparam int OTP_ST_ERR = 2;
   localparam int OTP_MODE_ECCOFF = 3;
   localparam int OTP_MODE_WRMODE = 5;
   localparam int OTP_FLAG_DEFECT = 0;
   // ****************************************
   // sizes and reset values
   // ****************************************
   localparam int OTP_BUF_BYTES = 64;
   localparam int OTP_MEM_BYTES = 768;
   localparam logic [7:0] OTP_PAGE_COUNT = 8'h0c;
   localparam logic [9:0] OTP_FLAG_ADDR = 10'h2a0;
   localparam logic [7:0] OTP_RST_BYTE = 8'h00;
   localparam logic [15:0] OTP_RST_CNT = 16'h0000;
   // recommended pulse count at a 12.0 MHz input clock (25 us)
   localparam logic [15:0] OTP_PULSE_CNT_TYP = 16'h012c;

   typedef enum logic [1:0] {
      OTP_IDLE = 2'b00,
      OTP_PROG = 2'b01,
      OTP_READ = 2'b10
   } otp_state_e;
endpackage : otp_pkg

// ### hw/otp_fuse_array.sv
// Purpose: fuse storage of 768 bytes plus one check bit per byte
// Assumes: bits can only be burned from 0 to 1
// Notes: rst blanks the array, standing in for a fresh part in simulation
`timescale 1ns/1ps
module otp_fuse_array (
   input wire logic clk,
   input wire logic rst,
   input wire logic burnEn,
   input wire logic [9:0] addr,
   input wire logic [7:0] burnBits,
   input wire logic burnCheck,
   output logic [7:0] rdData,
   output logic rdCheck,
   output logic [7:0] flagByte
);
   import otp_pkg::*;
   logic [7:0] cell_r [OTP_MEM_BYTES];
   logic checkBit_r [OTP_MEM_BYTES];

   // ****************************************
   // burn: or-in only, never clears a bit
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < OTP_MEM_BYTES; i++) begin
            cell_r[i] <= OTP_RST_BYTE;
            checkBit_r[i] <= 1'b0;
         end
      end else if (burnEn && addr < 10'(OTP_MEM_BYTES)) begin
         cell_r[addr] <= cell_r[addr] | burnBits;
         checkBit_r[addr] <= checkBit_r[addr] | burnCheck;
      end
   end

   assign rdData = (addr < 10'(OTP_MEM_BYTES)) ? cell_r[addr] : OTP_RST_BYTE;
   assign rdCheck = (addr < 10'(OTP_MEM_BYTES)) ? checkBit_r[addr] : 1'b0;
   assign flagByte = cell_r[OTP_FLAG_ADDR];
endmodule : otp_fuse_array

// ### hw/otp_ctrl.sv
// Purpose: register-side controller for programming and reading the fuse memory
// Assumes: register writes and reads arrive as one-cycle strobes on the serial port logic
// Notes: buffer, page and mode writes are ignored while an operation runs
`timescale 1ns/1ps
module otp_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData_r,
   output logic busy_r,
   output logic progPulse_r,
   output logic defectListPresent_r
);
   import otp_pkg::*;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic isBuf(input logic [15:0] a);
      isBuf = (a >= OTP_ADDR_BUF_FIRST) && (a <= OTP_ADDR_BUF_LAST);
   endfunction : isBuf

   function automatic logic [5:0] bufIdx(input logic [15:0] a);
      logic [15:0] d;
      d = a - OTP_ADDR_BUF_FIRST;
      bufIdx = d[5:0];
   endfunction : bufIdx

   // page number times 64 plus byte index
   function automatic logic [9:0] memAddr(input logic [3:0] pg, input logic [5:0] idx);
      memAddr = {pg, idx};
   endfunction : memAddr

   otp_state_e state_r;
   logic [1:0] ctrl_r;
   logic [7:0] page_r;
   logic [7:0] mode_r;
   logic [15:0] pulseCnt_r;
   logic [7:0] buf_r [OTP_BUF_BYTES];
   logic armed_r;
   logic [7:0] lastVal_r;
   logic readReady_r;
   logic writeReady_r;
   logic eccErr_r;
   logic [3:0] opPage_r;
   logic eccOn_r;
   logic [5:0] byteIdx_r;
   logic [2:0] bitIdx_r;
   logic [15:0] cnt_r;
   logic [7:0] rdData;
   logic rdCheck;
   logic [7:0] flagByte;
   logic idle;
   logic wrCtrl;
   logic wrPage;
   logic wrLast;
   logic startProg;
   logic startRead;
   logic [3:0] startPage;
   logic [15:0] pulseEnd;
   logic [15:0] divEnd;
   logic bitDone;
   logic byteDone;
   logic errSet;
   logic burnEn;
   logic [7:0] burnBits;
   logic burnCheck;

   assign idle = (state_r == OTP_IDLE);
   assign wrCtrl = regWrEn && regAddr == OTP_ADDR_CTRL;
   assign wrPage = regWrEn && regAddr == OTP_ADDR_PAGE;
   assign wrLast = regWrEn && regAddr == OTP_ADDR_BUF_LAST;

   // ****************************************
   // operation start decode
   // ****************************************
   // a second identical write to the last byte fires programming
   assign startProg = idle && wrLast && armed_r && regWrData == lastVal_r
                      && ctrl_r == OTP_CTRL_PROG && page_r < OTP_PAGE_COUNT;
   // a read starts when read direction is set, or a page is chosen under it
   assign startRead = idle && ((wrCtrl && regWrData[1:0] == OTP_CTRL_READ && page_r < OTP_PAGE_COUNT)
                      || (wrPage && ctrl_r == OTP_CTRL_READ && regWrData < OTP_PAGE_COUNT));
   assign startPage = wrPage ? regWrData[3:0] : page_r[3:0];

   // a zero count still gives a one-cycle pulse rather than a wrap to 65536
   assign pulseEnd = (pulseCnt_r == OTP_RST_CNT) ? OTP_RST_CNT : pulseCnt_r - 16'h0001;
   assign divEnd = (16'h0001 << mode_r[1:0]) - 16'h0001;
   assign bitDone = (state_r == OTP_PROG) && cnt_r == pulseEnd;
   assign byteDone = (state_r == OTP_READ) && cnt_r == divEnd;
   assign errSet = byteDone && eccOn_r && ((^rdData) != rdCheck);

   // burn the bit at the end of its pulse; check bit rides on the last bit
   assign burnEn = bitDone;
   assign burnBits = buf_r[byteIdx_r] & (8'h01 << bitIdx_r);
   assign burnCheck = eccOn_r && bitIdx_r == 3'h7 && (^buf_r[byteIdx_r]);

   otp_fuse_array uArray (
      .clk(clk),
      .rst(rst),
      .burnEn(burnEn),
      .addr(memAddr(opPage_r, byteIdx_r)),
      .burnBits(burnBits),
      .burnCheck(burnCheck),
      .rdData(rdData),
      .rdCheck(rdCheck),
      .flagByte(flagByte)
   );

   // ****************************************
   // configuration registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r <= 2'h0;
         page_r <= OTP_RST_BYTE;
         mode_r <= OTP_RST_BYTE;
         pulseCnt_r <= OTP_RST_CNT;
      end else if (regWrEn && idle) begin
         unique case (regAddr)
            OTP_ADDR_CTRL: ctrl_r <= regWrData[1:0];
            OTP_ADDR_PAGE: page_r <= regWrData;
            OTP_ADDR_MODE: mode_r <= regWrData;
            OTP_ADDR_CNT_HI: pulseCnt_r[15:8] <= regWrData;
            OTP_ADDR_CNT_LO: pulseCnt_r[7:0] <= regWrData;
            default: ;
         endcase
      end
   end

   // ****************************************
   // page buffer: never cleared by an operation
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < OTP_BUF_BYTES; i++) begin
            buf_r[i] <= OTP_RST_BYTE;
         end
      end else if (byteDone) begin
         buf_r[byteIdx_r] <= rdData;
      end else if (regWrEn && idle && isBuf(regAddr)) begin
         buf_r[bufIdx(regAddr)] <= regWrData;
      end
   end

   // trigger arming: any other buffer write breaks the pair
   always_ff @(posedge clk) begin
      if (rst) begin
         armed_r <= 1'b0;
         lastVal_r <= OTP_RST_BYTE;
      end else if (startProg || !idle) begin
         armed_r <= 1'b0;
      end else if (wrLast) begin
         armed_r <= 1'b1;
         lastVal_r <= regWrData;
      end else if (regWrEn && isBuf(regAddr)) begin
         armed_r <= 1'b0;
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= OTP_IDLE;
         opPage_r <= 4'h0;
         eccOn_r <= 1'b0;
         byteIdx_r <= 6'h00;
         bitIdx_r <= 3'h0;
         cnt_r <= OTP_RST_CNT;
      end else begin
         unique case (state_r)
            OTP_IDLE: begin
               cnt_r <= OTP_RST_CNT;
               byteIdx_r <= 6'h00;
               bitIdx_r <= 3'h0;
               if (startProg || startRead) begin
                  opPage_r <= startPage;
                  eccOn_r <= !mode_r[OTP_MODE_ECCOFF];
                  state_r <= startProg ? OTP_PROG : OTP_READ;
               end
            end
            // one pulse slot per bit, 8 bits by 64 bytes, whether burned or not
            OTP_PROG: begin
               if (bitDone) begin
                  cnt_r <= OTP_RST_CNT;
                  bitIdx_r <= bitIdx_r + 3'h1;
                  if (bitIdx_r == 3'h7) begin
                     byteIdx_r <= byteIdx_r + 6'h01;
                     if (byteIdx_r == 6'h3f) begin
                        state_r <= OTP_IDLE;
                     end
                  end
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
            OTP_READ: begin
               if (byteDone) begin
                  cnt_r <= OTP_RST_CNT;
                  byteIdx_r <= byteIdx_r + 6'h01;
                  if (byteIdx_r == 6'h3f) begin
                     state_r <= OTP_IDLE;
                  end
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
            default: state_r <= OTP_IDLE;
         endcase
      end
   end

   // ****************************************
   // status flags: set beats clear
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         readReady_r <= 1'b0;
         writeReady_r <= 1'b0;
         eccErr_r <= 1'b0;
      end else begin
         if (state_r == OTP_READ && byteDone && byteIdx_r == 6'h3f) begin
            readReady_r <= 1'b1;
         end else if (startProg || startRead) begin
            readReady_r <= 1'b0;
         end
         if (bitDone && bitIdx_r == 3'h7 && byteIdx_r == 6'h3f) begin
            writeReady_r <= 1'b1;
         end else if (startProg || startRead) begin
            writeReady_r <= 1'b0;
         end
         if (errSet) begin
            eccErr_r <= 1'b1;
         end else if (wrCtrl && regWrData[OTP_CTRL_ERRCLR]) begin
            eccErr_r <= 1'b0;
         end
      end
   end

   // ****************************************
   // read-back and outputs
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         regRdData_r <= OTP_RST_BYTE;
      end else if (regRdEn) begin
         if (isBuf(regAddr)) begin
            regRdData_r <= buf_r[bufIdx(regAddr)];
         end else begin
            unique case (regAddr)
               OTP_ADDR_CTRL: regRdData_r <= {6'h00, ctrl_r};
               OTP_ADDR_STATUS: regRdData_r <= {5'h00, eccErr_r, writeReady_r, readReady_r};
               OTP_ADDR_PAGE: regRdData_r <= page_r;
               OTP_ADDR_MODE: regRdData_r <= mode_r;
               OTP_ADDR_CNT_HI: regRdData_r <= pulseCnt_r[15:8];
               OTP_ADDR_CNT_LO: regRdData_r <= pulseCnt_r[7:0];
               default: regRdData_r <= OTP_RST_BYTE;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_r <= 1'b0;
         progPulse_r <= 1'b0;
         defectListPresent_r <= 1'b0;
      end else begin
         busy_r <= !idle || startProg || startRead;
         // pulse stands for the whole slot of a bit that is actually burned, so it lasts the loaded count
         progPulse_r <= (state_r == OTP_PROG) && burnBits != OTP_RST_BYTE;
         defectListPresent_r <= flagByte[OTP_FLAG_DEFECT];
      end
   end
endmodule : otp_ctrl

// ### tb/otp_ctrl_properties.sv
// Purpose: concurrent checks on the fuse memory controller ports
// Assumes: one clock domain, synchronous active-high reset
// Notes: page and mode are shadowed here so start conditions can be judged
`timescale 1ns/1ps
module otp_ctrl_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData_r,
   input wire logic busy_r,
   input wire logic progPulse_r,
   input wire logic defectListPresent_r
);
   import otp_pkg::*;
   logic [7:0] pg;
   logic [7:0] md;
   logic rdGo;
   // shadows follow only writes taken while idle, as the controller does
   always_ff @(posedge clk) begin
      if (rst) begin
         pg <= 8'h00;
         md <= 8'h00;
      end else if (regWrEn && !busy_r) begin
         if (regAddr == OTP_ADDR_PAGE) pg <= regWrData;
         if (regAddr == OTP_ADDR_MODE) md <= regWrData;
      end
   end
   assign rdGo = regWrEn && !busy_r && regAddr == OTP_ADDR_CTRL && regWrData[1:0] == OTP_CTRL_READ;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_RST: assert property (disable iff (1'b0) rst |=>
      !busy_r && !progPulse_r && !defectListPresent_r && regRdData_r == 8'h00) else $error("reset left an output set");
   AST_READ_START: assert property (rdGo && pg < OTP_PAGE_COUNT |=> busy_r)
      else $error("read did not start");
   AST_PAGE_REFUSE: assert property (rdGo && pg >= OTP_PAGE_COUNT |=> !busy_r)
      else $error("read started on a missing page");
   AST_READ_LEN: assert property (rdGo && pg < OTP_PAGE_COUNT && md[1:0] == 2'h0 |=>
      (busy_r throughout (1'b1 ##63 1'b1)) ##[1:2] !busy_r) else $error("read length wrong");
   AST_PULSE_BUSY: assert property (progPulse_r |-> busy_r)
      else $error("pulse outside an operation");
   AST_UNMAPPED: assert property (regRdEn && regAddr == 16'h3250 |=> regRdData_r == 8'h00)
      else $error("unmapped read not zero");
   AST_ERRCLR: assert property (regRdEn && regAddr == OTP_ADDR_CTRL |=> !regRdData_r[OTP_CTRL_ERRCLR])
      else $error("error clear bit reads back set");
   AST_RD_STABLE: assert property (!regRdEn |=> $stable(regRdData_r))
      else $error("read data moved without a read");
endmodule : otp_ctrl_properties
bind otp_ctrl otp_ctrl_properties i_otp_ctrl_properties (.clk(clk), .rst(rst), .regWrEn(regWrEn),
   .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData_r(regRdData_r),
   .busy_r(busy_r), .progPulse_r(progPulse_r), .defectListPresent_r(defectListPresent_r));

// ### tb/otp_host_model.sv
// Purpose: host on the register port
// Assumes: strobes change on the falling edge and stand for one rising edge
// Notes: idle address and data show the inverse of the last value
`timescale 1ns/1ps
module otp_host_model (
   input wire logic clk,
   input wire logic busy_r,
   output logic regWrEn,
   output logic regRdEn,
   output logic [15:0] regAddr,
   output logic [7:0] regWrData
);
   import otp_pkg::*;
   logic [7:0] pageData [64];
   initial begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 16'h0000;
      regWrData = 8'h00;
   end
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge clk);
      regWrEn = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
   endtask : wr
   task automatic rd(input logic [15:0] a);
      @(negedge clk);
      regRdEn = 1'b1;
      regAddr = a;
      @(negedge clk);
      regRdEn = 1'b0;
      regAddr = ~a;
   endtask : rd
   // every byte is rewritten since the buffer keeps the old page
   task automatic load(input logic [7:0] pg);
      wr(OTP_ADDR_PAGE, pg);
      for (int i = 0; i < 64; i++) begin
         wr(OTP_ADDR_BUF_FIRST + 16'(i), pageData[i]);
      end
   endtask : load
   // bounded so a stuck busy cannot hang the host
   task automatic waitIdle();
      for (int i = 0; i < 4000 && busy_r !== 1'b0; i++) begin
         @(negedge clk);
      end
   endtask : waitIdle
endmodule : otp_host_model

// ### tb/test_otp_nvm_access_controller.sv
// Purpose: self-checking bench for the fuse memory controller
// Assumes: pulse count 2 keeps programming short
// Notes: read results are noted in a queue and checked by a monitor
`timescale 1ns/1ps
module test_otp_nvm_access_controller;
   import otp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic regWrEn, regRdEn, busy_r, progPulse_r, defectListPresent_r, rdSeen;
   logic [15:0] regAddr;
   logic [7:0] regWrData, regRdData_r;
   logic [15:0] notes [$];
   logic [15:0] n;
   logic [7:0] expData [64];
   int fails = 0;
   int checks = 0;
   int pulses = 0;
   int seed = 90015;
   // sensor mode select sits outside this block; writing 0 keeps the sensor idle
   localparam logic [15:0] STANDBY_ADDR = 16'h0100;
   localparam logic [15:0] REGS [9] = '{OTP_ADDR_CTRL, OTP_ADDR_STATUS, OTP_ADDR_PAGE, OTP_ADDR_BUF_FIRST,
      OTP_ADDR_BUF_LAST, OTP_ADDR_MODE, OTP_ADDR_CNT_HI, OTP_ADDR_CNT_LO, 16'h3250};
   always #10 clk = ~clk;
   otp_host_model i_otp_host_model (.clk(clk), .busy_r(busy_r), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData));
   otp_ctrl i_otp_ctrl (.clk(clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
      .regWrData(regWrData), .regRdData_r(regRdData_r), .busy_r(busy_r), .progPulse_r(progPulse_r),
      .defectListPresent_r(defectListPresent_r));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic chk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
      notes.push_back({m, e});
      i_otp_host_model.rd(a);
   endtask : chk
   always @(posedge clk) rdSeen <= regRdEn;
   // cycles with the burn pulse high, cleared by the bench before each trigger
   always @(posedge clk) begin
      if (progPulse_r === 1'b1) pulses++;
   end
   always @(negedge clk) begin
      if (rdSeen === 1'b1) begin
         n = notes.pop_front();
         cmp(regRdData_r & n[15:8], n[7:0]);
      end
   end
   task automatic progPage(input logic [7:0] pg, input logic [7:0] mode);
      int ones;
      ones = 0;
      for (int i = 0; i < 64; i++) ones += $countones(i_otp_host_model.pageData[i]);
      i_otp_host_model.wr(OTP_ADDR_CNT_HI, 8'h00);
      i_otp_host_model.wr(OTP_ADDR_CNT_LO, 8'h02);
      i_otp_host_model.wr(OTP_ADDR_MODE, mode);
      i_otp_host_model.wr(OTP_ADDR_CTRL, {6'h00, OTP_CTRL_PROG});
      repeat (2) begin
         i_otp_host_model.load(pg);
         cmp({7'h00, busy_r}, 8'h00);
         pulses = 0;
         i_otp_host_model.wr(OTP_ADDR_BUF_LAST, i_otp_host_model.pageData[63]);
         cmp({7'h00, busy_r}, 8'h01);
         i_otp_host_model.waitIdle();
         cmp({7'h00, busy_r}, 8'h00);
         // each set bit gets one pulse of the loaded count, 2 cycles
         cmp(16'(pulses), 16'(ones * 2));
      end
      chk(OTP_ADDR_STATUS, 8'h02, 8'h02);
   endtask : progPage
   task automatic readPage(input logic [7:0] pg, input logic [7:0] mode, input int cyc, input logic err);
      int k;
      k = 0;
      i_otp_host_model.wr(OTP_ADDR_CTRL, 8'h00);
      i_otp_host_model.wr(OTP_ADDR_PAGE, pg);
      i_otp_host_model.wr(OTP_ADDR_MODE, mode);
      i_otp_host_model.wr(OTP_ADDR_CTRL, {6'h00, OTP_CTRL_READ});
      while (busy_r === 1'b1 && k < 5000) begin
         @(negedge clk);
         k++;
      end
      cmp(8'(k + 1 >= cyc && k <= cyc + 2), 8'h01);
      chk(OTP_ADDR_STATUS, 8'h05, {5'h00, err, 2'h1});
   endtask : readPage
   task automatic finish_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      i_otp_host_model.wr(STANDBY_ADDR, 8'h00);
      foreach (REGS[i]) chk(REGS[i], 8'hff, 8'h00);
      for (int i = 0; i < 64; i++) begin
         expData[i] = 8'($random(seed));
         i_otp_host_model.pageData[i] = expData[i];
      end
      progPage(8'h03, 8'h20);
      chk(OTP_ADDR_BUF_FIRST + 16'h0005, 8'hff, expData[5]);
      chk(OTP_ADDR_MODE, 8'hff, 8'h20);
      chk(OTP_ADDR_CNT_LO, 8'hff, 8'h02);
      // blank the buffer so the read proves the transfer
      i_otp_host_model.wr(OTP_ADDR_CTRL, 8'h00);
      for (int i = 0; i < 64; i++) i_otp_host_model.pageData[i] = 8'h00;
      i_otp_host_model.load(8'h03);
      readPage(8'h03, 8'h03, 512, 1'b0);
      for (int i = 0; i < 64; i++) chk(OTP_ADDR_BUF_FIRST + 16'(i), 8'hff, expData[i]);
      for (int i = 0; i < 64; i++) i_otp_host_model.pageData[i] = 8'h01;
      progPage(8'h04, 8'h28);
      readPage(8'h04, 8'h00, 64, 1'b1);
      i_otp_host_model.wr(OTP_ADDR_CTRL, 8'h04);
      chk(OTP_ADDR_CTRL, 8'hff, 8'h00);
      chk(OTP_ADDR_STATUS, 8'h04, 8'h00);
      readPage(8'h04, 8'h08, 64, 1'b0);
      readPage(8'h04, 8'h09, 128, 1'b0);
      readPage(8'h04, 8'h0a, 256, 1'b0);
      // with read direction still set, choosing a page starts the read
      i_otp_host_model.wr(OTP_ADDR_PAGE, 8'h03);
      cmp({7'h00, busy_r}, 8'h01);
      i_otp_host_model.waitIdle();
      chk(OTP_ADDR_BUF_FIRST + 16'h0005, 8'hff, expData[5]);
      i_otp_host_model.wr(OTP_ADDR_CTRL, 8'h00);
      i_otp_host_model.wr(OTP_ADDR_PAGE, OTP_PAGE_COUNT);
      i_otp_host_model.wr(OTP_ADDR_CTRL, {6'h00, OTP_CTRL_READ});
      cmp({7'h00, busy_r}, 8'h00);
      cmp({7'h00, defectListPresent_r}, 8'h00);
      // maker rows stay zero so nothing is burned there
      for (int i = 0; i < 64; i++) i_otp_host_model.pageData[i] = 8'h00;
      i_otp_host_model.pageData[32] = 8'h01;
      progPage(8'h0a, 8'h20);
      @(negedge clk);
      cmp({7'h00, defectListPresent_r}, 8'h01);
      finish_test();
   end
   initial begin
      #800000;
      fails++;
      finish_test();
   end
endmodule : test_otp_nvm_access_controller
